// ===== core/mxs_pkg.sv
/*
 * Shared constants for the switch-control front end: widths, pin
 * sampling indices, serial word layout, reset values and the mode type.
 * Assumes nothing beyond a SystemVerilog compiler; holds definitions only.
 */
package mxs_pkg;

    // widths
    localparam int SHIFT_W = 4;
    localparam int ADDR_W = 3;
    localparam int BANK_W = 4;
    localparam int NUM_SW = 8;
    localparam int BANK_SEL_W = 2;

    // positions of the sampled pins inside the synchroniser vector
    localparam int IN_CLEAR = 0;
    localparam int IN_SEL_N = 1;
    localparam int IN_A_MSB = 2;
    localparam int IN_A_MID = 3;
    localparam int IN_A_LSB = 4;
    localparam int IN_MODE = 5;
    localparam int IN_DUAL = 6;
    localparam int IN_GATE = 7;
    localparam int IN_W = 8;

    // serial word layout
    localparam int SWORD_ADDR_LSB = 0;
    localparam int SWORD_ADDR_MSB = 2;
    localparam int SWORD_ON_BIT = 3;

    // reset values; clear and select idle high
    localparam logic [IN_W-1:0] IN_RST = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
    localparam logic GATE_RST = 1'h0;
    localparam logic [SHIFT_W-1:0] WORD_RST = 4'h0;
    localparam logic [NUM_SW-1:0] SW_RST = 8'h00;

    typedef enum logic {
        MXS_MODE_PARALLEL = 1'b0,
        MXS_MODE_SERIAL = 1'b1
    } mxs_mode_t;

endpackage : mxs_pkg

// ===== core/mxs_shift.sv
/*
 * Serial shift register on the shift clock, with its last stage as the
 * daisy-chain output.
 * Assumes chip select and serial data are timed to the shift clock by
 * the controller, so they are taken on that clock with no synchroniser.
 */
`timescale 1ns/1ps
module mxs_shift #(
    parameter int SHIFT_W = mxs_pkg::SHIFT_W
) (
    input wire logic shift_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic din,
    output logic [SHIFT_W-1:0] word,
    output logic dout
);
    import mxs_pkg::*;

    logic [SHIFT_W-1:0] shift_ff;
    logic [SHIFT_W-1:0] nxt_shift;

    // shift only while selected
    always_comb begin
        if (cs_n) begin
            nxt_shift = shift_ff;
        end else begin
            nxt_shift = {shift_ff[SHIFT_W-2:0], din};
        end
    end

    always_ff @(posedge shift_clk or posedge rst) begin
        if (rst) begin
            shift_ff <= WORD_RST;
        end else begin
            shift_ff <= nxt_shift;
        end
    end

    assign word = shift_ff;
    assign dout = shift_ff[SHIFT_W-1];

    sequence burst_s;
        (!cs_n) ##1 (!cs_n) [*3];
    endsequence

    shift_in_a: assert property (
        @(posedge shift_clk) disable iff (rst)
        !cs_n |=> shift_ff[0] == $past(din))
        else $error("serial bit not taken on shift clock rise");

    daisy_out_a: assert property (
        @(posedge shift_clk) disable iff (rst)
        burst_s |=> dout == $past(din, 4))
        else $error("serial output does not show bit four shifts back");

    idle_hold_a: assert property (
        @(posedge shift_clk) disable iff (rst)
        cs_n |=> $stable(shift_ff))
        else $error("shift register moved while deselected");

endmodule : mxs_shift

// ===== core/mxs_ctrl.sv
/*
 * Switch-control front end: parallel latched address port or serial
 * shift port decides which of the switches are closed.
 * Assumes CLK is free running; all pins but the serial ones are
 * asynchronous to it and pass two flip-flops; the shift clock pin also
 * clocks the shift register as a second domain.
 */
//
// Notes on behaviour
// - dual mode select high gives two banks switched alike, low gives one mux over all switches.
// - in serial mode a low clear resets the latches and the shift register and opens all switches.
// - in parallel mode a low clear resets the latches and opens all switches.
// - in parallel mode the shared latch/select pin is a transparent latch enable for address and gate.
// - in serial mode the shared latch/select pin is an active-low chip select framing each transfer.
// - in parallel single-mux mode the top pin is the address msb, in dual mode it is ignored.
// - in serial mode the top pin is the shift clock and data is taken on its rising edge.
// - the middle pin is an address bit in parallel mode and serial data in serial mode.
// - the bottom pin is the address lsb in parallel mode and the shift register output in serial mode.
// - the serial output keeps driving while chip select is high.
// - the serial output shows the updated shift register after each shift clock rise.
// - a low gate opens every switch, a high gate lets the selection conduct.
// - in serial mode the gate acts directly with no clock or latch of its own.
// - in parallel mode the gate is held while the strobe is high and passes while it is low.
// - interface select low picks parallel, high picks serial and enables the output driver.
`timescale 1ns/1ps
module mxs_ctrl #(
    parameter int SHIFT_W = mxs_pkg::SHIFT_W,
    parameter int NUM_SW = mxs_pkg::NUM_SW
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CLEAR_N,
    input wire logic LATCH_OR_SELECT_N,
    input wire logic ADDR_MSB_OR_SHIFT_CLOCK,
    input wire logic ADDR_MID_OR_SERIAL_IN,
    input wire logic ADDR_LSB_OR_SERIAL_OUT_I,
    output logic ADDR_LSB_OR_SERIAL_OUT_O,
    output logic ADDR_LSB_OR_SERIAL_OUT_OE,
    input wire logic INTERFACE_SELECT,
    input wire logic DUAL_MODE_SELECT,
    input wire logic CHANNEL_GATE,
    output logic [NUM_SW-1:0] SW_CLOSED
);
    import mxs_pkg::*;

    logic [IN_W-1:0] pin_raw;
    logic [IN_W-1:0] sync1_ff;
    logic [IN_W-1:0] sync2_ff;
    logic clear_s;
    logic sel_n_s;
    logic gate_s;
    logic dual_s;
    mxs_mode_t mode_s;
    logic [ADDR_W-1:0] addr_s;
    logic cs_d_ff;
    logic cs_rise;
    logic link_rst;
    logic link_cs_n;
    logic [SHIFT_W-1:0] shift_word;
    logic [ADDR_W-1:0] par_addr_ff;
    logic par_gate_ff;
    logic [SHIFT_W-1:0] serial_word_ff;
    logic [NUM_SW-1:0] sw_ff;
    logic [NUM_SW-1:0] nxt_sw;
    logic oe_ff;
    logic [ADDR_W-1:0] sel_addr;
    logic sel_on;

    // pin sampling, two stages
    assign pin_raw[IN_CLEAR] = CLEAR_N;
    assign pin_raw[IN_SEL_N] = LATCH_OR_SELECT_N;
    assign pin_raw[IN_A_MSB] = ADDR_MSB_OR_SHIFT_CLOCK;
    assign pin_raw[IN_A_MID] = ADDR_MID_OR_SERIAL_IN;
    assign pin_raw[IN_A_LSB] = ADDR_LSB_OR_SERIAL_OUT_I;
    assign pin_raw[IN_MODE] = INTERFACE_SELECT;
    assign pin_raw[IN_DUAL] = DUAL_MODE_SELECT;
    assign pin_raw[IN_GATE] = CHANNEL_GATE;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sync1_ff <= IN_RST;
            sync2_ff <= IN_RST;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
        end
    end

    assign clear_s = sync2_ff[IN_CLEAR];
    assign sel_n_s = sync2_ff[IN_SEL_N];
    assign gate_s = sync2_ff[IN_GATE];
    assign dual_s = sync2_ff[IN_DUAL];
    assign mode_s = mxs_mode_t'(sync2_ff[IN_MODE]);
    // address pins in parallel mode
    assign addr_s = {sync2_ff[IN_A_MSB], sync2_ff[IN_A_MID],
                     sync2_ff[IN_A_LSB]};

    // end of a serial frame, seen in the system domain
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cs_d_ff <= IN_RST[IN_SEL_N];
        end else begin
            cs_d_ff <= sel_n_s;
        end
    end

    assign cs_rise = (mode_s == MXS_MODE_SERIAL) && sel_n_s && !cs_d_ff;

    // shift side; clear reaches it at once in serial mode
    assign link_rst = RESET | (~CLEAR_N & INTERFACE_SELECT);
    // parallel mode keeps the shift register still
    assign link_cs_n = LATCH_OR_SELECT_N | ~INTERFACE_SELECT;

    mxs_shift #(
        .SHIFT_W(SHIFT_W)
    ) u_shift (
        .shift_clk(ADDR_MSB_OR_SHIFT_CLOCK),
        .rst(link_rst),
        .cs_n(link_cs_n),
        .din(ADDR_MID_OR_SERIAL_IN),
        .word(shift_word),
        .dout(ADDR_LSB_OR_SERIAL_OUT_O)
    );

    // output driver on in serial mode regardless of chip select
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            oe_ff <= 1'h0;
        end else begin
            oe_ff <= (mode_s == MXS_MODE_SERIAL);
        end
    end

    assign ADDR_LSB_OR_SERIAL_OUT_OE = oe_ff;

    // parallel latch, transparent while strobe low
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            par_addr_ff <= ADDR_RST;
            par_gate_ff <= GATE_RST;
        end else if (!clear_s) begin
            par_addr_ff <= ADDR_RST;
            par_gate_ff <= GATE_RST;
        end else if (mode_s == MXS_MODE_PARALLEL && !sel_n_s) begin
            // last value before the strobe rises is held
            par_addr_ff <= addr_s;
            par_gate_ff <= gate_s;
        end
    end

    // serial word taken only once the frame closes;
    // word is quiet while select is high, so the synced edge qualifies it
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            serial_word_ff <= WORD_RST;
        end else if (!clear_s) begin
            serial_word_ff <= WORD_RST;
        end else if (cs_rise) begin
            serial_word_ff <= shift_word;
        end
    end

    // selection and gating
    always_comb begin
        nxt_sw = SW_RST;
        if (mode_s == MXS_MODE_SERIAL) begin
            sel_addr = serial_word_ff[SWORD_ADDR_MSB:SWORD_ADDR_LSB];
            sel_on = serial_word_ff[SWORD_ON_BIT] & gate_s;
        end else begin
            sel_addr = par_addr_ff;
            sel_on = par_gate_ff;
        end
        if (!clear_s) begin
            sel_on = 1'b0;
        end
        if (sel_on) begin
            if (dual_s) begin
                // msb ignored, both banks follow
                nxt_sw[sel_addr[BANK_SEL_W-1:0]] = 1'b1;
                nxt_sw[BANK_W + int'(sel_addr[BANK_SEL_W-1:0])] = 1'b1;
            end else begin
                nxt_sw[sel_addr] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sw_ff <= SW_RST;
        end else begin
            sw_ff <= nxt_sw;
        end
    end

    assign SW_CLOSED = sw_ff;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence clear_held_s;
        (!CLEAR_N) [*4];
    endsequence

    sequence gate_off_s;
        (!CHANNEL_GATE && (INTERFACE_SELECT || !LATCH_OR_SELECT_N)) [*5];
    endsequence

    sequence deselected_s;
        (INTERFACE_SELECT && LATCH_OR_SELECT_N) [*4];
    endsequence

    sequence ser_run_s;
        (INTERFACE_SELECT && CHANNEL_GATE && CLEAR_N) [*4];
    endsequence

    sequence frame_open_s;
        (mode_s == MXS_MODE_SERIAL && !sel_n_s && clear_s) [*2];
    endsequence

    out_enable_a: assert property (
        INTERFACE_SELECT [*4] |-> ADDR_LSB_OR_SERIAL_OUT_OE)
        else $error("serial driver not enabled in serial mode");

    par_no_drive_a: assert property (
        (!INTERFACE_SELECT) [*4] |-> !ADDR_LSB_OR_SERIAL_OUT_OE)
        else $error("serial driver on in parallel mode");

    clear_opens_a: assert property (
        clear_held_s |-> SW_CLOSED == SW_RST)
        else $error("switches not open under clear");

    gate_off_a: assert property (
        gate_off_s |-> SW_CLOSED == SW_RST)
        else $error("switches closed with gate low");

    single_mux_a: assert property (
        !$past(dual_s) |-> $onehot0(SW_CLOSED))
        else $error("more than one switch closed in single mode");

    dual_banks_a: assert property (
        $past(dual_s) |->
            SW_CLOSED[BANK_W-1:0] == SW_CLOSED[NUM_SW-1:BANK_W])
        else $error("banks differ in dual mode");

    latch_hold_a: assert property (
        (mode_s == MXS_MODE_PARALLEL && sel_n_s && clear_s)
            |=> $stable(par_addr_ff) && $stable(par_gate_ff))
        else $error("parallel latch moved with strobe high");

    latch_pass_a: assert property (
        (mode_s == MXS_MODE_PARALLEL && !sel_n_s && clear_s)
            |=> par_addr_ff == $past(addr_s)
                && par_gate_ff == $past(gate_s))
        else $error("parallel latch not transparent with strobe low");

    frame_hold_a: assert property (
        (!sel_n_s && clear_s) |=> $stable(serial_word_ff))
        else $error("serial word changed inside a frame");

    frame_load_a: assert property (
        (cs_rise && clear_s) |=> serial_word_ff == $past(shift_word))
        else $error("serial word not loaded at frame end");

    drive_deselect_a: assert property (
        deselected_s |-> ADDR_LSB_OR_SERIAL_OUT_OE)
        else $error("serial driver off while deselected");

    shift_clear_a: assert property (
        (!CLEAR_N && INTERFACE_SELECT) |-> shift_word == WORD_RST)
        else $error("shift register not cleared in serial mode");

    latch_clear_a: assert property (
        !clear_s |=> par_addr_ff == ADDR_RST && par_gate_ff == GATE_RST)
        else $error("parallel latch not cleared");

    word_clear_a: assert property (
        !clear_s |=> serial_word_ff == WORD_RST)
        else $error("serial word not cleared");

    word_hold_a: assert property (
        (!cs_rise && clear_s) |=> $stable(serial_word_ff))
        else $error("serial word changed outside a frame end");

    par_gate_a: assert property (
        (mode_s == MXS_MODE_PARALLEL && clear_s)
            |=> (SW_CLOSED != SW_RST) == $past(par_gate_ff))
        else $error("parallel gate not applied to the switches");

    par_select_a: assert property (
        (mode_s == MXS_MODE_PARALLEL && clear_s && par_gate_ff && !dual_s)
            |=> SW_CLOSED[$past(par_addr_ff)])
        else $error("latched address does not close its switch");

    bank_select_a: assert property (
        (mode_s == MXS_MODE_PARALLEL && clear_s && par_gate_ff && dual_s)
            |=> SW_CLOSED[$past(par_addr_ff[BANK_SEL_W-1:0])]
                && SW_CLOSED[BANK_W + $past(par_addr_ff[BANK_SEL_W-1:0])])
        else $error("dual mode does not close a switch in each bank");

    serial_gate_a: assert property (
        ser_run_s |-> (SW_CLOSED != SW_RST)
            == $past(serial_word_ff[SWORD_ON_BIT]))
        else $error("serial gate or on bit not applied to the switches");

    frame_quiet_a: assert property (
        frame_open_s ##0 ($stable(gate_s) && $stable(dual_s))
            |=> $stable(SW_CLOSED))
        else $error("switches moved inside a serial frame");

endmodule : mxs_ctrl

// ===== dv/mxs_host.sv
/*
 * Host controller model that drives the switch-control pins.
 * Assumes the bench clock on clk; the shift clock moves only in frames.
 */
`timescale 1ns/1ps
module mxs_host (
    input wire logic clk,
    input wire logic dout,
    output logic clear_n,
    output logic sel_n,
    output logic a_msb,
    output logic a_mid,
    output logic a_lsb,
    output logic gate
);
    initial begin
        clear_n = 1'b1;
        sel_n = 1'b1;
        {a_msb, a_mid, a_lsb, gate} = 4'h0;
    end

    task automatic par_write(input logic [2:0] a, input logic g);
        @(posedge clk);
        sel_n <= 1'b0;
        {a_msb, a_mid, a_lsb, gate} <= {a, g};
        repeat (4) @(posedge clk);
        sel_n <= 1'b1;
        repeat (2) @(posedge clk);
        // hold time over, lines no longer show the old values
        {a_msb, a_mid, a_lsb, gate} <= ~{a, g};
    endtask : par_write

    task automatic ser_write(input logic [3:0] w, output logic [3:0] seen);
        @(posedge clk);
        sel_n <= 1'b0;
        a_msb <= 1'b0;
        #17;
        for (int i = 3; i >= 0; i--) begin
            a_mid = w[i];
            #62.5 a_msb = 1'b1;
            #50 seen[i] = dout;
            #12.5 a_msb = 1'b0;
        end
        a_mid = ~w[0];
        @(posedge clk);
        sel_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : ser_write

    task automatic pulse_clear;
        @(posedge clk);
        clear_n <= 1'b0;
        repeat (4) @(posedge clk);
        clear_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : pulse_clear

    task automatic set_gate(input logic g);
        @(posedge clk);
        gate <= g;
        repeat (4) @(posedge clk);
    endtask : set_gate
endmodule : mxs_host

// ===== dv/mxs_ctrl_test.sv
/*
 * Self-checking bench for the switch-control front end.
 * Assumes the host model drives the pins; the bench owns mode pins.
 */
`timescale 1ns/1ps
module mxs_ctrl_test;
    import mxs_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic mode = 1'b0;
    logic dual = 1'b0;
    logic clear_n, sel_n, a_msb, a_mid, a_lsb, gate, pin_o, pin_oe;
    logic [NUM_SW-1:0] sw;
    logic [3:0] seen;
    int failures = 0;
    int n_compared = 0;
    wire pin = pin_oe ? pin_o : a_lsb;

    always #25 clk = ~clk;

    mxs_host u_mxs_host (.clk(clk), .dout(pin), .clear_n(clear_n),
        .sel_n(sel_n), .a_msb(a_msb), .a_mid(a_mid), .a_lsb(a_lsb),
        .gate(gate));

    mxs_ctrl u_mxs_ctrl (.CLK(clk), .RESET(reset), .CLEAR_N(clear_n),
        .LATCH_OR_SELECT_N(sel_n), .ADDR_MSB_OR_SHIFT_CLOCK(a_msb),
        .ADDR_MID_OR_SERIAL_IN(a_mid), .ADDR_LSB_OR_SERIAL_OUT_I(pin),
        .ADDR_LSB_OR_SERIAL_OUT_O(pin_o),
        .ADDR_LSB_OR_SERIAL_OUT_OE(pin_oe), .INTERFACE_SELECT(mode),
        .DUAL_MODE_SELECT(dual), .CHANNEL_GATE(gate), .SW_CLOSED(sw));

    task automatic check(input logic [7:0] got, input logic [7:0] want,
            input string what);
        n_compared++;
        if (got !== want) begin
            failures++;
            $display("wrong value at %0t: %s got %h want %h", $time,
                what, got, want);
        end
    endtask : check

    function automatic logic [7:0] sel_exp(input logic [2:0] a,
            input logic on);
        if (!on) return 8'h00;
        if (dual) return 8'h11 << a[1:0];
        return 8'h01 << a;
    endfunction : sel_exp

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic t_reset;
        check(sw, 8'h00, "switches after reset");
        check({7'h0, pin_oe}, 8'h00, "driver in parallel");
        $display("reset test done");
    endtask : t_reset

    task automatic t_parallel;
        for (int d = 0; d < 2; d++) begin
            @(posedge clk);
            dual <= d[0];
            for (int a = 0; a < 8; a++) begin
                u_mxs_host.par_write(a[2:0], 1'b1);
                repeat (3) @(posedge clk);
                check(sw, sel_exp(a[2:0], 1'b1), "parallel sel");
            end
        end
        u_mxs_host.par_write(3'h5, 1'b0);
        repeat (3) @(posedge clk);
        check(sw, 8'h00, "gate low");
        u_mxs_host.par_write(3'h2, 1'b1);
        u_mxs_host.pulse_clear;
        check(sw, 8'h00, "parallel clear");
        $display("parallel test done");
    endtask : t_parallel

    task automatic t_serial;
        @(posedge clk);
        mode <= 1'b1;
        dual <= 1'b0;
        u_mxs_host.set_gate(1'b1);
        check({7'h0, pin_oe}, 8'h01, "driver in serial");
        u_mxs_host.pulse_clear;
        check({7'h0, pin}, 8'h00, "shift cleared");
        u_mxs_host.ser_write(4'hD, seen);
        check({4'h0, seen}, 8'h01, "chain out 1");
        check(sw, sel_exp(3'h5, 1'b1), "serial word");
        u_mxs_host.ser_write(4'hE, seen);
        check({4'h0, seen}, 8'h0B, "chain out 2");
        check({7'h0, pin}, 8'h01, "out while deselected");
        check(sw, sel_exp(3'h6, 1'b1), "serial word 2");
        u_mxs_host.set_gate(1'b0);
        check(sw, 8'h00, "serial gate low");
        u_mxs_host.set_gate(1'b1);
        check(sw, sel_exp(3'h6, 1'b1), "serial gate high");
        u_mxs_host.pulse_clear;
        check(sw, 8'h00, "serial clear");
        check({7'h0, pin}, 8'h00, "serial clear out");
        $display("serial test done");
    endtask : t_serial

    initial begin
        #(50 * 5000);
        failures++;
        $display("wrong value at %0t: run did not finish", $time);
        test_done();
    end

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_parallel();
        t_serial();
        test_done();
    end
endmodule : mxs_ctrl_test
